/* rtl/itt_interval_timer.sv */
// Notes on behaviour
// RQ1 - Three identical 16-bit counters, each programmed through a byte-wide data register.
// RQ2 - Counter 0 counts external clock edges; its rising output latches a pending request.
// RQ3 - Counter 0 gate input controls its counting when driven.
// RQ4 - Counter 1 is a 10 MHz rate generator driving a pin and controller input 3.
// RQ5 - Counter 2 runs at 10 MHz; when enabled its rising output raises a request.
// RQ6 - Mode 1 counts n to zero on trigger; a new n restarts the count.
// RQ7 - Mode 3 makes a square wave of n 10 MHz periods.
// RQ8 - Six byte registers on consecutive longwords: three data, control, status twice.
// RQ9 - Software configures via control byte and moves counts only through data registers.
// RQ10 - Select field 11 is a read-back command freezing count or status.
// RQ11 - Access field: latch, low only, high only, low then high; persists.
// RQ12 - A full 16-bit transfer takes two successive byte accesses in chosen order.
// RQ13 - Mode field: 011 continuous square wave, 000 single shot.
// RQ14 - Control bit 0 selects binary when clear and BCD when set.
// RQ15 - Completing the data write sequence starts the counter; in mode 1 the counter instead waits for a trigger.
// RQ16 - Interrupt status register sits at two aliases with address and direction dependent effect.
// RQ17 - Any status register access clears pending requests; reads return both request flags.
`timescale 1ns/1ps
module itt_interval_timer
  import itt_pkg::*;
(
  input  wire logic        ref_clk_in,                         // 50 MHz clock
  input  wire logic        rst_in,                             // Async reset, active high
  input  wire logic [15:0] bus_addr_in,                        // Local bus byte offset
  input  wire logic        bus_wr_in,                          // Write strobe, one cycle
  input  wire logic        bus_rd_in,                          // Read strobe, one cycle
  input  wire logic [7:0]  bus_wdata_in,                       // Write data
  output logic      [7:0]  bus_rdata_out,                      // Read data, valid cycle after strobe
  input  wire logic        ext_clk0_in,                        // Counter 0 external clock
  input  wire logic        gate0_in,                           // Counter 0 gate
  input  wire logic        trig1_in,                           // Counter 1 gate/trigger
  input  wire logic        trig2_in,                           // Counter 2 gate/trigger
  output logic             tmr0_pin_out,                       // Counter 0 output
  output logic             tmr1_pin_out,                       // Counter 1 off-module output
  output logic             tmr2_pin_out,                       // Counter 2 off-module output
  output logic             vme_interface_controller_irq3_out,  // Counter 1 to local input 3
  output logic             irq_tmr0_out,                       // Counter 0 request pending
  output logic             irq_tmr2_out                        // Counter 2 request pending
);

  // ----------------------------------------------------------------
  // Shared state
  // ----------------------------------------------------------------
  logic [15:0] cnt_q      [3];
  logic [15:0] reload_q   [3];
  logic [15:0] latch_q    [3];
  logic [7:0]  status_q   [3];
  logic [7:0]  rd_byte    [3];
  logic [7:0]  wlow_q     [3];
  logic [1:0]  rw_q       [3];
  logic [2:0]  mode_q     [3];
  logic [2:0]  tick;
  logic [2:0]  gate;
  logic [2:0]  data_wr;
  logic [2:0]  data_rd;
  logic [2:0]  bcd_q;
  logic [2:0]  out_q;
  logic [2:0]  out_prev_q;
  logic [2:0]  run_q;
  logic [2:0]  load_pend_q;
  logic [2:0]  null_q;
  logic [2:0]  wflip_q;
  logic [2:0]  rflip_q;
  logic [2:0]  latch_v_q;
  logic [2:0]  status_v_q;
  logic [2:0]  gate_prev_q;
  logic [2:0]  trig_q;
  logic [2:0]  fast_cnt_q;
  logic        fast_tick_q;
  logic        ext_prev_q;
  logic        irq0_q;
  logic        irq2_q;
  logic        irq2_en_q;
  logic        ctl_wr;
  logic        irq_acc;
  logic [7:0]  rdata_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Control and status register decode
  assign ctl_wr  = bus_wr_in && (bus_addr_in == OFS_CTRL_BYTE);
  assign irq_acc = (bus_wr_in || bus_rd_in) &&
                   ((bus_addr_in == OFS_IRQ_STAT_A) || (bus_addr_in == OFS_IRQ_STAT_B));  // RQ16

  // ----------------------------------------------------------------
  // Count clocks
  // ----------------------------------------------------------------
  // 10 MHz tick from the 50 MHz clock; one pulse per five cycles
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fast_cnt_q  <= 3'h0;
      fast_tick_q <= 1'b0;
    end else begin
      fast_tick_q <= (fast_cnt_q == FAST_DIV_LAST);
      fast_cnt_q  <= (fast_cnt_q == FAST_DIV_LAST) ? 3'h0 : fast_cnt_q + 3'h1;
    end
  end

  // External clock edge; the pin must stay below half the system clock rate
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_clk0_in;
    end
  end

  assign tick = {fast_tick_q, fast_tick_q, ext_clk0_in & ~ext_prev_q};  // RQ2 RQ4 RQ5
  assign gate = {trig2_in, trig1_in, gate0_in};                         // RQ3

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_cnt
    logic [15:0] next_n;
    logic        done;
    logic        ctl_mine;
    logic        rb_mine;
    logic [15:0] dec_v;
    logic [15:0] src;

    assign data_wr[i] = bus_wr_in && (bus_addr_in == OFS_CNT0_DATA + 16'(i) * OFS_CNT_STRIDE);  // RQ8 RQ1
    assign data_rd[i] = bus_rd_in && (bus_addr_in == OFS_CNT0_DATA + 16'(i) * OFS_CNT_STRIDE);  // RQ8
    assign ctl_mine   = ctl_wr && (bus_wdata_in[CTL_SEL_LO +: 2] == 2'(i));                    // RQ10
    assign rb_mine    = ctl_wr && (bus_wdata_in[CTL_SEL_LO +: 2] == SEL_READBACK)
                        && bus_wdata_in[RB_SEL_LO + i];                                         // RQ10
    assign dec_v      = itt_dec(cnt_q[i], bcd_q[i]);                                            // RQ14

    // Assemble the written count and flag the end of the byte sequence
    always_comb begin
      next_n = {8'h00, bus_wdata_in};
      done   = 1'b0;
      unique case (rw_q[i])
        RW_LSB: begin
          done = data_wr[i];                                                   // RQ11
        end
        RW_MSB: begin
          next_n = {bus_wdata_in, 8'h00};
          done   = data_wr[i];                                                 // RQ11
        end
        RW_BOTH: begin
          next_n = {bus_wdata_in, wlow_q[i]};
          done   = data_wr[i] && wflip_q[i];                                   // RQ12
        end
        default: begin
          done = 1'b0;
        end
      endcase
    end

    // Write byte pointer; low byte is held until the high byte arrives
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
        wflip_q[i] <= 1'b0;
        wlow_q[i]  <= 8'h00;
      end else if (ctl_mine && bus_wdata_in[CTL_RW_LO +: 2] != RW_LATCH) begin
        wflip_q[i] <= 1'b0;
      end else if (data_wr[i] && rw_q[i] == RW_BOTH) begin
        wflip_q[i] <= ~wflip_q[i];                                             // RQ12
        if (!wflip_q[i]) begin
          wlow_q[i] <= bus_wdata_in;
        end
      end
    end

    // Configuration, persists until the next non-latch control byte for this counter
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
        rw_q[i]   <= RW_LSB;
        mode_q[i] <= MODE_SINGLE;
        bcd_q[i]  <= 1'b0;
      end else if (ctl_mine && bus_wdata_in[CTL_RW_LO +: 2] != RW_LATCH) begin
        rw_q[i]   <= bus_wdata_in[CTL_RW_LO +: 2];                             // RQ11
        mode_q[i] <= bus_wdata_in[CTL_MODE_LO +: 3];                           // RQ13
        bcd_q[i]  <= bus_wdata_in[CTL_BCD];                                    // RQ14
      end
    end

    // Trigger capture: a gate rising edge waits here for the next count tick
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
        gate_prev_q[i] <= 1'b0;
        trig_q[i]      <= 1'b0;
      end else begin
        gate_prev_q[i] <= gate[i];
        if (gate[i] && !gate_prev_q[i]) begin
          trig_q[i] <= 1'b1;
        end else if (tick[i] || ctl_mine) begin
          trig_q[i] <= 1'b0;
        end
      end
    end

    // Counting engine; a non-latch control byte stops the counter until a count is loaded, or in mode 1 until a trigger
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
        cnt_q[i]       <= CNT_RESET;
        reload_q[i]    <= CNT_RESET;
        run_q[i]       <= 1'b0;
        load_pend_q[i] <= 1'b0;
        null_q[i]      <= 1'b0;
        out_q[i]       <= 1'b0;
      end else if (ctl_mine && bus_wdata_in[CTL_RW_LO +: 2] != RW_LATCH) begin
        run_q[i]       <= 1'b0;
        load_pend_q[i] <= 1'b0;
        null_q[i]      <= 1'b1;
        out_q[i]       <= (bus_wdata_in[CTL_MODE_LO +: 3] != MODE_SINGLE);     // RQ13
      end else begin
        if (done) begin
          reload_q[i]    <= next_n;
          load_pend_q[i] <= 1'b1;                                              // RQ15
          null_q[i]      <= 1'b1;
        end
        if (tick[i]) begin
          unique case (mode_q[i])
            MODE_TRIG: begin
              if (trig_q[i] || (load_pend_q[i] && run_q[i])) begin
                cnt_q[i]       <= reload_q[i];                                 // RQ6
                out_q[i]       <= 1'b0;
                run_q[i]       <= 1'b1;
                load_pend_q[i] <= done;
                null_q[i]      <= done;
              end else if (run_q[i]) begin
                cnt_q[i] <= dec_v;                                             // RQ6
                if (cnt_q[i] == 16'h0001) begin
                  out_q[i] <= 1'b1;
                  run_q[i] <= 1'b0;
                end
              end
            end
            MODE_RATE, MODE_SQUARE: begin
              if (load_pend_q[i] && !run_q[i]) begin
                cnt_q[i]       <= reload_q[i];                                 // RQ15
                out_q[i]       <= 1'b1;
                run_q[i]       <= 1'b1;
                load_pend_q[i] <= done;
                null_q[i]      <= done;
              end else if (run_q[i] && gate[i]) begin
                if (cnt_q[i] == 16'h0001) begin
                  cnt_q[i]       <= reload_q[i];                               // RQ4 RQ5
                  out_q[i]       <= 1'b1;
                  load_pend_q[i] <= done;
                  null_q[i]      <= done;
                end else if (mode_q[i] == MODE_RATE) begin
                  cnt_q[i] <= dec_v;
                  out_q[i] <= (cnt_q[i] != 16'h0002);                          // RQ4
                end else begin
                  cnt_q[i] <= dec_v;
                  out_q[i] <= (dec_v > {1'b0, reload_q[i][15:1]});             // RQ7
                end
              end
            end
            default: begin
              if (load_pend_q[i]) begin
                cnt_q[i]       <= reload_q[i];                                 // RQ15
                out_q[i]       <= 1'b0;
                run_q[i]       <= 1'b1;
                load_pend_q[i] <= done;
                null_q[i]      <= done;
              end else if (run_q[i] && gate[i]) begin
                cnt_q[i] <= dec_v;                                             // RQ13
                if (cnt_q[i] == 16'h0001) begin
                  out_q[i] <= 1'b1;
                  run_q[i] <= 1'b0;
                end
              end
            end
          endcase
        end
      end
    end

    // Count and status latches, frozen until software has read them
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
        latch_q[i]    <= CNT_RESET;
        latch_v_q[i]  <= 1'b0;
        status_q[i]   <= 8'h00;
        status_v_q[i] <= 1'b0;
        rflip_q[i]    <= 1'b0;
      end else begin
        if ((ctl_mine && bus_wdata_in[CTL_RW_LO +: 2] == RW_LATCH)
            || (rb_mine && !bus_wdata_in[RB_NO_COUNT])) begin
          if (!latch_v_q[i]) begin
            latch_q[i]   <= cnt_q[i];                                          // RQ11 RQ10
            latch_v_q[i] <= 1'b1;
          end
        end else if (ctl_mine) begin
          rflip_q[i] <= 1'b0;
        end else if (data_rd[i] && !status_v_q[i]) begin
          if (rw_q[i] == RW_BOTH) begin
            rflip_q[i] <= ~rflip_q[i];                                         // RQ12
          end
          if (rw_q[i] != RW_BOTH || rflip_q[i]) begin
            latch_v_q[i] <= 1'b0;
          end
        end
        if (rb_mine && !bus_wdata_in[RB_NO_STAT] && !status_v_q[i]) begin
          status_q[i]   <= {out_q[i], null_q[i], rw_q[i], mode_q[i], bcd_q[i]};  // RQ10
          status_v_q[i] <= 1'b1;
        end else if (data_rd[i]) begin
          status_v_q[i] <= 1'b0;
        end
      end
    end

    // Byte presented by this counter's data register
    always_comb begin
      src = latch_v_q[i] ? latch_q[i] : cnt_q[i];
      if (status_v_q[i]) begin
        rd_byte[i] = status_q[i];                                              // RQ10
      end else if (rw_q[i] == RW_MSB || (rw_q[i] == RW_BOTH && rflip_q[i])) begin
        rd_byte[i] = src[15:8];                                                // RQ12
      end else begin
        rd_byte[i] = src[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  // Output history for rising edge detection
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_prev_q <= 3'h0;
    end else begin
      out_prev_q <= out_q;
    end
  end

  // Pending flags; a new edge in the clearing cycle wins over the clear
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq0_q    <= 1'b0;
      irq2_q    <= 1'b0;
      irq2_en_q <= 1'b0;
    end else begin
      if (out_q[0] && !out_prev_q[0]) begin
        irq0_q <= 1'b1;                                                        // RQ2
      end else if (irq_acc) begin
        irq0_q <= 1'b0;                                                        // RQ17
      end
      if (out_q[2] && !out_prev_q[2] && irq2_en_q) begin
        irq2_q <= 1'b1;                                                        // RQ5
      end else if (irq_acc) begin
        irq2_q <= 1'b0;                                                        // RQ17
      end
      if (bus_wr_in && bus_addr_in == OFS_IRQ_STAT_B) begin
        irq2_en_q <= bus_wdata_in[IRQ_BIT_EN2];                                // RQ16
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Registered read mux; unmapped offsets and the write-only control byte read zero
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= RDATA_NONE;
    end else if (bus_rd_in) begin
      rdata_q <= RDATA_NONE;
      for (int k = 0; k < 3; k++) begin
        if (data_rd[k]) begin
          rdata_q <= rd_byte[k];                                               // RQ9
        end
      end
      if (irq_acc) begin
        rdata_q[IRQ_BIT_CNT0] <= irq0_q;                                       // RQ17
        rdata_q[IRQ_BIT_CNT2] <= irq2_q;
        rdata_q[IRQ_BIT_EN2]  <= irq2_en_q;
      end
    end
  end

  assign bus_rdata_out                     = rdata_q;
  assign tmr0_pin_out                      = out_q[0];
  assign tmr1_pin_out                      = out_q[1];
  assign tmr2_pin_out                      = out_q[2];
  assign vme_interface_controller_irq3_out = out_q[1];   // RQ4
  assign irq_tmr0_out                      = irq0_q;
  assign irq_tmr2_out                      = irq2_q;

endmodule

/* rtl/itt_pkg.sv */
package itt_pkg;

  // ----------------------------------------------------------------
  // Register map (local I/O bus byte offsets)
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_CNT0_DATA  = 16'h4000;
  localparam logic [15:0] OFS_CNT1_DATA  = 16'h4004;
  localparam logic [15:0] OFS_CNT2_DATA  = 16'h4008;
  localparam logic [15:0] OFS_CTRL_BYTE  = 16'h400c;
  localparam logic [15:0] OFS_IRQ_STAT_A = 16'h4010;
  localparam logic [15:0] OFS_IRQ_STAT_B = 16'h4014;
  localparam logic [15:0] OFS_CNT_STRIDE = 16'h0004;

  // ----------------------------------------------------------------
  // Control byte fields
  // ----------------------------------------------------------------
  localparam int CTL_SEL_LO  = 6;
  localparam int CTL_RW_LO   = 4;
  localparam int CTL_MODE_LO = 1;
  localparam int CTL_BCD     = 0;
  localparam int RB_NO_COUNT = 5;  // Read-back: low means latch count
  localparam int RB_NO_STAT  = 4;  // Read-back: low means latch status
  localparam int RB_SEL_LO   = 1;  // Read-back: counter select bits 3:1

  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] RW_LATCH     = 2'h0;
  localparam logic [1:0] RW_LSB       = 2'h1;
  localparam logic [1:0] RW_MSB       = 2'h2;
  localparam logic [1:0] RW_BOTH      = 2'h3;

  localparam logic [2:0] MODE_SINGLE  = 3'h0;
  localparam logic [2:0] MODE_TRIG    = 3'h1;
  localparam logic [2:0] MODE_RATE    = 3'h2;
  localparam logic [2:0] MODE_SQUARE  = 3'h3;

  // Interrupt status register bits
  localparam int IRQ_BIT_CNT0 = 0;
  localparam int IRQ_BIT_CNT2 = 1;
  localparam int IRQ_BIT_EN2  = 2;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [7:0]  RDATA_NONE = 8'h00;
  localparam int CLK_HZ      = 50_000_000;
  localparam int FAST_HZ     = 10_000_000;
  localparam int FAST_DIV    = CLK_HZ / FAST_HZ;
  localparam logic [2:0] FAST_DIV_LAST = 3'(FAST_DIV - 1);

  // Count down by one in binary or four-digit BCD; zero wraps to the top
  function automatic logic [15:0] itt_dec(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic        borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - 16'h0001;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (borrow) begin
          if (r[4*k +: 4] == 4'h0) begin
            r[4*k +: 4] = 4'h9;
          end else begin
            r[4*k +: 4] = r[4*k +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

endpackage

/* test/itt_interval_timer_checker.sv */
`timescale 1ns/1ps
// --------------------------------------------------------------
// Port-level checks of the interval timer
// --------------------------------------------------------------
module itt_interval_timer_checker
  import itt_pkg::*;
(
  input wire logic        ref_clk_in,                         // Clock
  input wire logic        rst_in,                             // Reset
  input wire logic [15:0] bus_addr_in,                        // Offset
  input wire logic        bus_wr_in,                          // Write strobe
  input wire logic        bus_rd_in,                          // Read strobe
  input wire logic [7:0]  bus_rdata_out,                      // Read data
  input wire logic        tmr0_pin_out,                       // Counter 0 out
  input wire logic        tmr1_pin_out,                       // Counter 1 out
  input wire logic        tmr2_pin_out,                       // Counter 2 out
  input wire logic        vme_interface_controller_irq3_out,  // Input 3
  input wire logic        irq_tmr0_out,                       // Request 0
  input wire logic        irq_tmr2_out                        // Request 2
);
  logic       hist0_q;
  logic       hist2_q;
  logic       stat_acc;
  logic       mapped;
  logic       quiet;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // Access decode; quiet excludes a clear that collides with a set still in the flag pipeline
  assign stat_acc = (bus_rd_in | bus_wr_in) & (bus_addr_in == OFS_IRQ_STAT_A | bus_addr_in == OFS_IRQ_STAT_B);
  assign mapped   = bus_addr_in inside {OFS_CNT0_DATA, OFS_CNT1_DATA, OFS_CNT2_DATA, OFS_IRQ_STAT_A, OFS_IRQ_STAT_B};
  assign quiet    = !(tmr0_pin_out & !hist0_q) & !(tmr2_pin_out & !hist2_q);

  // Output levels one clock back, as the design's edge detector sees them
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hist0_q <= 1'b0;
      hist2_q <= 1'b0;
    end else begin
      hist0_q <= tmr0_pin_out;
      hist2_q <= tmr2_pin_out;
    end
  end

  sequence s_stat_rd;
    bus_rd_in && (bus_addr_in == OFS_IRQ_STAT_A || bus_addr_in == OFS_IRQ_STAT_B);
  endsequence

  irq3_mirror_a: assert property (vme_interface_controller_irq3_out == tmr1_pin_out)
    else $error("controller input 3 differs from counter 1 output");
  irq0_raise_a: assert property ($rose(tmr0_pin_out) |=> irq_tmr0_out)
    else $error("counter 0 rise did not set its request");
  irq0_hold_a: assert property (irq_tmr0_out && !stat_acc |=> irq_tmr0_out)
    else $error("counter 0 request dropped without a status access");
  irq2_cause_a: assert property ($rose(irq_tmr2_out) |-> $past(tmr2_pin_out) && !$past(tmr2_pin_out, 2))
    else $error("counter 2 request rose without an output rise");
  irq_clear_a: assert property (stat_acc && quiet |=> !irq_tmr0_out && !irq_tmr2_out)
    else $error("status access did not clear requests");
  stat_read_a: assert property (s_stat_rd |=> bus_rdata_out[7:3] == 5'h00 &&
    bus_rdata_out[1] == $past(irq_tmr2_out) && bus_rdata_out[0] == $past(irq_tmr0_out))
    else $error("status read returned wrong flags");
  rdata_hold_a: assert property (!bus_rd_in |=> $stable(bus_rdata_out))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (bus_rd_in && !mapped |=> bus_rdata_out == 8'h00)
    else $error("unreadable offset returned nonzero");
endmodule

bind itt_interval_timer itt_interval_timer_checker i_itt_interval_timer_checker (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .bus_addr_in(bus_addr_in), .bus_wr_in(bus_wr_in),
  .bus_rd_in(bus_rd_in), .bus_rdata_out(bus_rdata_out), .tmr0_pin_out(tmr0_pin_out),
  .tmr1_pin_out(tmr1_pin_out), .tmr2_pin_out(tmr2_pin_out), .irq_tmr0_out(irq_tmr0_out),
  .vme_interface_controller_irq3_out(vme_interface_controller_irq3_out), .irq_tmr2_out(irq_tmr2_out));

/* test/testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
// --------------------------------------------------------------
// Register-level bench of the interval timer
// --------------------------------------------------------------
module testbench;
  logic        clk, rst, wr, rd, ext0, g0, t1, t2, p0, p1, p2, i3, q0, q2;
  logic [15:0] addr;
  logic [7:0]  wd, rdat;
  int          miscompares, samples_checked, hi, lo;

  itt_interval_timer i_itt_interval_timer (
    .ref_clk_in(clk), .rst_in(rst), .bus_addr_in(addr), .bus_wr_in(wr), .bus_rd_in(rd),
    .bus_wdata_in(wd), .bus_rdata_out(rdat), .ext_clk0_in(ext0), .gate0_in(g0), .trig1_in(t1),
    .trig2_in(t2), .tmr0_pin_out(p0), .tmr1_pin_out(p1), .tmr2_pin_out(p2),
    .vme_interface_controller_irq3_out(i3), .irq_tmr0_out(q0), .irq_tmr2_out(q2));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // One-cycle strobes launched at the falling edge
  task automatic wrb(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // Data is registered, so it is looked at a full cycle after the strobe
  task automatic rdb(input logic [15:0] a, input logic [7:0] ex, input logic [7:0] m, input string nm);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    `CHK(nm, ex, rdat & m)
  endtask

  // External counter 0 edges, two clocks high and two low
  task automatic pulse0(input int n);
    repeat (n) begin
      @(negedge clk);
      ext0 = 1'b1;
      repeat (2) @(negedge clk);
      ext0 = 1'b0;
      @(negedge clk);
    end
  endtask

  // Length of the current level of counter 1, bounded
  task automatic span(input logic v, output int c);
    c = 0;
    while (p1 === v && c < 300) begin
      @(negedge clk);
      c++;
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The run needs about five hundred clocks; ten thousand means a hang
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end

  initial begin
    {rst, wr, rd, ext0, g0, t1, t2} = 7'h40;
    addr = 16'h0000;
    wd = 8'h00;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    `CHK("irq0 reset", 1'b0, q0)
    // Low gate freezes counter 0; a latch then returns low byte first
    wrb(16'h400c, 8'h30);
    wrb(16'h4000, 8'h34);
    wrb(16'h4000, 8'h12);
    pulse0(3);
    wrb(16'h400c, 8'h00);
    rdb(16'h4000, 8'h34, 8'hff, "cnt0 low");
    rdb(16'h4000, 8'h12, 8'hff, "cnt0 high");
    // BCD decrement of 10 gives 09, not 0f
    wrb(16'h400c, 8'h31);
    wrb(16'h4000, 8'h10);
    wrb(16'h4000, 8'h00);
    pulse0(1);
    g0 = 1'b1;
    pulse0(1);
    wrb(16'h400c, 8'h00);
    rdb(16'h4000, 8'h09, 8'hff, "bcd low");
    rdb(16'h4000, 8'h00, 8'hff, "bcd high");
    pulse0(12);
    `CHK("cnt0 out", 1'b1, p0)
    `CHK("irq0 set", 1'b1, q0)
    rdb(16'h4010, 8'h01, 8'hff, "status a");
    `CHK("irq0 clear", 1'b0, q0)
    rdb(16'h4018, 8'h00, 8'hff, "unmapped");
    rdb(16'h400c, 8'h00, 8'hff, "ctrl read");
    // Counter 1 square wave of 10 ticks: 25 clocks each level
    t1 = 1'b1;
    wrb(16'h400c, 8'h76);
    wrb(16'h4004, 8'h0a);
    wrb(16'h4004, 8'h00);
    span(1'b1, hi);
    span(1'b0, lo);
    span(1'b1, hi);
    span(1'b0, lo);
    `CHK("square high", 25, hi)
    `CHK("square low", 25, lo)
    wrb(16'h400c, 8'he4);
    rdb(16'h4004, 8'h36, 8'h7f, "readback status");
    // Counter 2 request only while enabled through the second alias
    wrb(16'h4014, 8'h04);
    t2 = 1'b1;
    wrb(16'h400c, 8'hb6);
    wrb(16'h4008, 8'h04);
    wrb(16'h4008, 8'h00);
    repeat (60) @(negedge clk);
    `CHK("irq2 set", 1'b1, q2)
    rdb(16'h4014, 8'h06, 8'hff, "status b");
    wrb(16'h4014, 8'h00);
    wrb(16'h4010, 8'h00);
    repeat (60) @(negedge clk);
    rdb(16'h4010, 8'h00, 8'hff, "irq2 masked");
    // Mode 1: trigger starts 5 ticks low; a rewrite restarts it
    t1 = 1'b0;
    wrb(16'h400c, 8'h52);
    wrb(16'h4004, 8'h05);
    repeat (10) @(negedge clk);
    `CHK("m1 idle", 1'b1, p1)
    t1 = 1'b1;
    repeat (15) @(negedge clk);
    `CHK("m1 run", 1'b0, p1)
    wrb(16'h4004, 8'h05);
    repeat (18) @(negedge clk);
    `CHK("m1 restart", 1'b0, p1)
    repeat (20) @(negedge clk);
    `CHK("m1 done", 1'b1, p1)
    // High byte only, then counter 1 as a rate generator: one tick low in four
    wrb(16'h400c, 8'h20);
    wrb(16'h4000, 8'h12);
    pulse0(1);
    rdb(16'h4000, 8'h12, 8'hff, "msb read");
    wrb(16'h400c, 8'h54);
    wrb(16'h4004, 8'h04);
    span(1'b1, hi);
    span(1'b0, lo);
    span(1'b1, hi);
    `CHK("rate low", 5, lo)
    `CHK("rate high", 15, hi)
    end_of_test();
  end
endmodule
